// >>> logic/txa_pkg.sv
package txa_pkg;
  // ==========================================================
  // register offsets (byte addresses on the plain port)
  localparam logic [7:0] TXA_ADDR_RAW_WORD   = 8'h00;
  localparam logic [7:0] TXA_ADDR_DL_PTR     = 8'h04;
  localparam logic [7:0] TXA_ADDR_BASE       = 8'h08;
  localparam logic [7:0] TXA_ADDR_FETCH_CFG  = 8'h0c;
  localparam logic [7:0] TXA_ADDR_STATUS     = 8'h10;
  // ==========================================================
  // widths
  localparam int TXA_AW = 24;
  localparam int TXA_CW = 11;
  // ==========================================================
  // texel-fetch config fields
  localparam int TXA_CFG_WLO    = 0;
  localparam int TXA_CFG_WMID   = 3;
  localparam int TXA_CFG_WHIGH  = 6;
  localparam int TXA_CFG_ORIGIN = 9;
  localparam int TXA_CFG_FMT    = 10;
  localparam int TXA_CFG_WRAPW  = 14;
  localparam int TXA_CFG_WRAPH  = 18;
  localparam logic [31:0] TXA_CFG_RESET = 32'h0000_0000;
  // ==========================================================
  // texel formats: bytes-per-texel selector
  typedef enum logic [3:0] {
    TXA_FMT_8BPP  = 4'h0,
    TXA_FMT_16BPP = 4'h1,
    TXA_FMT_32BPP = 4'h2,
    TXA_FMT_YUV   = 4'h3,
    TXA_FMT_CI4   = 4'h4
  } txa_fmt_t;
  typedef enum logic [1:0] {
    TXA_ST_IDLE = 2'b00,
    TXA_ST_ADDR = 2'b01
  } txa_state_t;
endpackage

// >>> logic/txa_texture_address.sv
// Chosen here: the register addresses and the address-and-strobe port.
module txa_texture_address
  import txa_pkg::*;
(
  // clock and reset
  input  wire  logic                       clk,
  input  wire  logic                       rst,
  // register port
  input  wire  logic [7:0]                 regAddr,
  input  wire  logic [31:0]                regWdata,
  input  wire  logic                       regWr,
  input  wire  logic                       regRd,
  output logic [31:0]                      regRdata,
  // fragment input from scissor/stipple
  input  wire  logic                       fragValid,
  input  wire  logic                       fragPass,
  input  wire  logic [txa_pkg::TXA_CW-1:0] fragS,
  input  wire  logic [txa_pkg::TXA_CW-1:0] fragT,
  // texel read output
  output logic                             texReqValid,
  output logic [txa_pkg::TXA_AW-1:0]       texTexelAddr,
  output logic [txa_pkg::TXA_AW+1:0]       texByteAddr,
  output logic [txa_pkg::TXA_CW-1:0]       texS,
  output logic [txa_pkg::TXA_CW-1:0]       texT,
  output logic [3:0]                       wrapWidthLog,
  output logic [3:0]                       wrapHeightLog,
  // raw memory write
  output logic                             memWrValid,
  output logic [txa_pkg::TXA_AW-1:0]       memWrAddr,
  output logic [31:0]                      memWrData
);
  import txa_pkg::*;

  // ==========================================================
  // registers
  logic [TXA_AW-1:0] dlPtr_q;
  logic [TXA_AW-1:0] base_q;
  logic [31:0]       cfg_q;
  logic [31:0]       rdData_q;
  logic [31:0]       storeCount_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dlPtr_q <= '0;
    end else if (regWr && regAddr == TXA_ADDR_DL_PTR) begin
      dlPtr_q <= regWdata[TXA_AW-1:0];
    end else if (regWr && regAddr == TXA_ADDR_RAW_WORD) begin
      dlPtr_q <= dlPtr_q + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      base_q <= '0;
      cfg_q  <= TXA_CFG_RESET;
    end else if (regWr) begin
      if (regAddr == TXA_ADDR_BASE) begin
        base_q <= regWdata[TXA_AW-1:0];
      end
      if (regAddr == TXA_ADDR_FETCH_CFG) begin
        cfg_q <= regWdata;
      end
    end
  end

  // ==========================================================
  // fast download: raw words straight to memory
  // the download never touches cfg_q, base_q or the address pipe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      memWrValid   <= 1'b0;
      memWrAddr    <= '0;
      memWrData    <= '0;
      storeCount_q <= '0;
    end else begin
      memWrValid <= regWr && regAddr == TXA_ADDR_RAW_WORD;
      if (regWr && regAddr == TXA_ADDR_RAW_WORD) begin
        memWrAddr    <= dlPtr_q;
        memWrData    <= regWdata;
        storeCount_q <= storeCount_q + 1'b1;
      end
    end
  end

  // ==========================================================
  // read port
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdData_q <= '0;
    end else if (regRd) begin
      case (regAddr)
        TXA_ADDR_DL_PTR:    rdData_q <= {{(32-TXA_AW){1'b0}}, dlPtr_q};
        TXA_ADDR_BASE:      rdData_q <= {{(32-TXA_AW){1'b0}}, base_q};
        TXA_ADDR_FETCH_CFG: rdData_q <= cfg_q;
        TXA_ADDR_STATUS:    rdData_q <= storeCount_q;
        default:            rdData_q <= '0;
      endcase
    end else begin
      rdData_q <= '0;
    end
  end
  assign regRdata = rdData_q;

  // ==========================================================
  // width decode: three 3-bit codes pick power-of-two terms
  // width = sum of (code==0 ? 0 : 1<<(code+4)) gives widths like 640
  function automatic logic [TXA_AW-1:0] codeTerm(input logic [2:0] c);
    // the shift amount is widened first so codes above 3 do not wrap
    codeTerm = (c == 3'h0) ? '0 : (TXA_AW'(1) << ({1'b0, c} + 4'h4));
  endfunction

  logic [TXA_AW-1:0] mapWidth;
  assign mapWidth = codeTerm(cfg_q[TXA_CFG_WLO+:3])
                  + codeTerm(cfg_q[TXA_CFG_WMID+:3])
                  + codeTerm(cfg_q[TXA_CFG_WHIGH+:3]);

  // wrap sizes are separate fields, never mixed into addressing
  assign wrapWidthLog  = cfg_q[TXA_CFG_WRAPW+:4];
  assign wrapHeightLog = cfg_q[TXA_CFG_WRAPH+:4];

  // ==========================================================
  // address stage
  txa_fmt_t          fmt;
  logic [1:0]        byteShift;
  logic              ci4;
  logic [TXA_AW-1:0] rowOffset;
  logic [TXA_AW-1:0] texelAddr;

  assign fmt = txa_fmt_t'(cfg_q[TXA_CFG_FMT+:4]);

  // ci4 packs two texels per byte, so the byte address halves instead
  always_comb begin
    byteShift = 2'd0;
    ci4       = 1'b0;
    case (fmt)
      TXA_FMT_8BPP:  byteShift = 2'd0;
      TXA_FMT_16BPP: byteShift = 2'd1;
      TXA_FMT_YUV:   byteShift = 2'd1;
      TXA_FMT_32BPP: byteShift = 2'd2;
      TXA_FMT_CI4:   ci4 = 1'b1;
      default:       byteShift = 2'd0;
    endcase
  end

  assign rowOffset = TXA_AW'(fragT * mapWidth);
  assign texelAddr = cfg_q[TXA_CFG_ORIGIN]
                   ? base_q + rowOffset + TXA_AW'(fragS)
                   : base_q - rowOffset + TXA_AW'(fragS);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      texReqValid  <= 1'b0;
      texTexelAddr <= '0;
      texByteAddr  <= '0;
      texS         <= '0;
      texT         <= '0;
    end else begin
      texReqValid <= fragValid && fragPass;
      if (fragValid && fragPass) begin
        texTexelAddr <= texelAddr;
        texS         <= fragS;
        texT         <= fragT;
        texByteAddr  <= ci4 ? {3'b000, texelAddr[TXA_AW-1:1]}
                            : ({2'b00, texelAddr} << byteShift);
      end
    end
  end

  // ==========================================================
  // checks
  sequence s_raw_write;
    regWr && regAddr == TXA_ADDR_RAW_WORD;
  endsequence
  sequence s_ptr_write;
    regWr && regAddr == TXA_ADDR_DL_PTR;
  endsequence
  sequence s_base_write;
    regWr && regAddr == TXA_ADDR_BASE;
  endsequence
  sequence s_cfg_write;
    regWr && regAddr == TXA_ADDR_FETCH_CFG;
  endsequence
  sequence s_frag_take;
    fragValid && fragPass;
  endsequence
  // a pointer load followed at once by a raw word: the store must use the new pointer
  sequence s_ptr_then_raw;
    s_ptr_write ##1 s_raw_write;
  endsequence
  sequence s_two_raw;
    s_raw_write ##1 s_raw_write;
  endsequence
  sequence s_read_at(logic [7:0] a);
    regRd && regAddr == a;
  endsequence

  a_raw_store_exact: assert property (@(posedge clk) disable iff (rst)
    regWr && regAddr == TXA_ADDR_RAW_WORD |=> memWrValid && memWrData == $past(regWdata))
    else $error("raw word not stored unchanged");
  a_ptr_advance: assert property (@(posedge clk) disable iff (rst)
    regWr && regAddr == TXA_ADDR_RAW_WORD |=> dlPtr_q == $past(dlPtr_q) + 1'b1
      && memWrAddr == $past(dlPtr_q))
    else $error("download pointer did not advance");
  a_ptr_load: assert property (@(posedge clk) disable iff (rst)
    s_ptr_then_raw |=> memWrAddr == $past(regWdata[TXA_AW-1:0], 2))
    else $error("pointer write not used by next store");
  a_dl_keeps_cfg: assert property (@(posedge clk) disable iff (rst)
    regWr && regAddr == TXA_ADDR_RAW_WORD |=> $stable(cfg_q) && $stable(base_q))
    else $error("download changed pipeline state");
  a_no_reject_fetch: assert property (@(posedge clk) disable iff (rst)
    !(fragValid && fragPass) |=> !texReqValid)
    else $error("rejected fragment fetched");
  a_addr_top: assert property (@(posedge clk) disable iff (rst)
    fragValid && fragPass && cfg_q[TXA_CFG_ORIGIN] |=> texTexelAddr ==
      TXA_AW'($past(base_q) + $past(fragT) * $past(mapWidth) + $past(fragS)))
    else $error("top-left address wrong");
  a_addr_bottom: assert property (@(posedge clk) disable iff (rst)
    fragValid && fragPass && !cfg_q[TXA_CFG_ORIGIN] |=> texTexelAddr ==
      TXA_AW'($past(base_q) - $past(fragT) * $past(mapWidth) + $past(fragS)))
    else $error("bottom-left address wrong");
  a_byte_32: assert property (@(posedge clk) disable iff (rst)
    fragValid && fragPass && fmt == TXA_FMT_32BPP |=> texByteAddr == {texTexelAddr, 2'b00})
    else $error("byte address not four times texel address");

  // ==========================================================
  // store side and register side
  a_store_only_raw: assert property (@(posedge clk) disable iff (rst)
    !(regWr && regAddr == TXA_ADDR_RAW_WORD) |=> !memWrValid)
    else $error("memory store without a raw word");
  a_store_burst: assert property (@(posedge clk) disable iff (rst)
    s_two_raw |=> memWrAddr == $past(memWrAddr) + 1'b1)
    else $error("burst stores not consecutive");
  a_ptr_hold: assert property (@(posedge clk) disable iff (rst)
    !regWr |=> $stable(dlPtr_q))
    else $error("download pointer moved without a write");
  a_ptr_load_direct: assert property (@(posedge clk) disable iff (rst)
    s_ptr_write |=> dlPtr_q == $past(regWdata[TXA_AW-1:0]))
    else $error("download pointer not loaded");
  a_count_advance: assert property (@(posedge clk) disable iff (rst)
    s_raw_write |=> storeCount_q == $past(storeCount_q) + 1'b1)
    else $error("store count did not advance");
  a_count_hold: assert property (@(posedge clk) disable iff (rst)
    !(regWr && regAddr == TXA_ADDR_RAW_WORD) |=> $stable(storeCount_q))
    else $error("store count moved without a store");
  a_base_load: assert property (@(posedge clk) disable iff (rst)
    s_base_write |=> base_q == $past(regWdata[TXA_AW-1:0]))
    else $error("window base not loaded");
  a_cfg_load: assert property (@(posedge clk) disable iff (rst)
    s_cfg_write |=> cfg_q == $past(regWdata))
    else $error("fetch config not loaded");
  a_cfg_hold: assert property (@(posedge clk) disable iff (rst)
    !regWr |=> $stable(cfg_q) && $stable(base_q))
    else $error("pipeline state moved without a write");
  a_read_ptr: assert property (@(posedge clk) disable iff (rst)
    s_read_at(TXA_ADDR_DL_PTR) |=> regRdata == {{(32-TXA_AW){1'b0}}, $past(dlPtr_q)})
    else $error("pointer read wrong");
  a_read_status: assert property (@(posedge clk) disable iff (rst)
    s_read_at(TXA_ADDR_STATUS) |=> regRdata == $past(storeCount_q))
    else $error("status read wrong");
  a_read_base: assert property (@(posedge clk) disable iff (rst)
    s_read_at(TXA_ADDR_BASE) |=> regRdata == {{(32-TXA_AW){1'b0}}, $past(base_q)})
    else $error("base read wrong");
  a_read_cfg: assert property (@(posedge clk) disable iff (rst)
    s_read_at(TXA_ADDR_FETCH_CFG) |=> regRdata == $past(cfg_q))
    else $error("config read wrong");
  a_read_raw_zero: assert property (@(posedge clk) disable iff (rst)
    s_read_at(TXA_ADDR_RAW_WORD) |=> regRdata == '0)
    else $error("raw word register read not zero");
  a_read_idle: assert property (@(posedge clk) disable iff (rst)
    !regRd |=> regRdata == '0)
    else $error("read data outside its cycle");

  // ==========================================================
  // fetch side
  a_fetch_pulse: assert property (@(posedge clk) disable iff (rst)
    s_frag_take |=> texReqValid)
    else $error("accepted fragment not fetched");
  a_coord_copy: assert property (@(posedge clk) disable iff (rst)
    s_frag_take |=> texS == $past(fragS) && texT == $past(fragT))
    else $error("coordinates not passed on");
  a_tex_hold: assert property (@(posedge clk) disable iff (rst)
    !(fragValid && fragPass) |=> $stable(texTexelAddr) && $stable(texByteAddr))
    else $error("address changed without a fragment");
  a_byte_8: assert property (@(posedge clk) disable iff (rst)
    fragValid && fragPass && fmt == TXA_FMT_8BPP |=> texByteAddr == {2'b00, texTexelAddr})
    else $error("byte address not equal to texel address");
  a_byte_16: assert property (@(posedge clk) disable iff (rst)
    fragValid && fragPass && (fmt == TXA_FMT_16BPP || fmt == TXA_FMT_YUV)
      |=> texByteAddr == {1'b0, texTexelAddr, 1'b0})
    else $error("byte address not twice texel address");
  a_byte_ci4: assert property (@(posedge clk) disable iff (rst)
    fragValid && fragPass && fmt == TXA_FMT_CI4
      |=> texByteAddr == {3'b000, texTexelAddr[TXA_AW-1:1]})
    else $error("index texel byte address not halved");
  a_wrap_fields: assert property (@(posedge clk) disable iff (rst)
    s_cfg_write |=> wrapWidthLog == $past(regWdata[TXA_CFG_WRAPW+:4])
      && wrapHeightLog == $past(regWdata[TXA_CFG_WRAPH+:4]))
    else $error("wrap sizes not taken from their own fields");
  a_dl_no_fetch: assert property (@(posedge clk) disable iff (rst)
    regWr && regAddr == TXA_ADDR_RAW_WORD && !fragValid |=> !texReqValid)
    else $error("download started a texel fetch");

  // ==========================================================
  // width decode
  a_width_zero: assert property (@(posedge clk) disable iff (rst)
    cfg_q[TXA_CFG_WLO+:9] == 9'h000 |-> mapWidth == '0)
    else $error("empty width code not zero");
  a_width_640: assert property (@(posedge clk) disable iff (rst)
    cfg_q[TXA_CFG_WLO+:9] == 9'h01d |-> mapWidth == 24'h280)
    else $error("width codes for 640 decoded wrong");
  a_width_1024: assert property (@(posedge clk) disable iff (rst)
    cfg_q[TXA_CFG_WLO+:9] == 9'h180 |-> mapWidth == 24'h400)
    else $error("width code for 1024 decoded wrong");
endmodule

// >>> sim/txa_mem_model.sv
// ==========================================================
// framebuffer memory seen by the raw download path
module txa_mem_model
  import txa_pkg::*;
(
  // clock
  input wire logic                       clk,
  // raw write from the block
  input wire logic                       memWrValid,
  input wire logic [txa_pkg::TXA_AW-1:0] memWrAddr,
  input wire logic [31:0]                memWrData
);
  timeunit 1ns;
  timeprecision 100ps;
  // sparse store: only locations the bench touches are kept
  logic [31:0] mem [int];
  int          writes = 0;
  always @(posedge clk) begin
    if (memWrValid === 1'b1) begin
      mem[int'(memWrAddr)] = memWrData;
      writes++;
    end
  end
endmodule

// >>> sim/tb.sv
module tb
  import txa_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {logic [2:0] k; logic [31:0] a; logic [31:0] b; logic [31:0] c;} txa_exp_t;
  logic clk = 1'b0, rst = 1'b1, regWr = 1'b0, regRd = 1'b0, fragValid = 1'b0, fragPass = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0, regRdata, memWrData, seed = 32'h647e, w, w0, cfg;
  logic [10:0] fragS = 11'h0, fragT = 11'h0, texS, texT, s = 11'h0, t = 11'h0;
  logic texReqValid, memWrValid, rdQ = 1'b0;
  logic [23:0] texTexelAddr, memWrAddr, p, b, ea;
  logic [25:0] texByteAddr;
  logic [3:0] wrapWidthLog, wrapHeightLog;
  int mismatches = 0, comparisons = 0;
  txa_exp_t expQ[$], e;
  always #2 clk = ~clk;
  txa_texture_address dut (.clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .fragValid(fragValid),
    .fragPass(fragPass), .fragS(fragS), .fragT(fragT), .texReqValid(texReqValid),
    .texTexelAddr(texTexelAddr), .texByteAddr(texByteAddr), .texS(texS), .texT(texT),
    .wrapWidthLog(wrapWidthLog), .wrapHeightLog(wrapHeightLog), .memWrValid(memWrValid),
    .memWrAddr(memWrAddr), .memWrData(memWrData));
  txa_mem_model mem (.clk(clk), .memWrValid(memWrValid), .memWrAddr(memWrAddr),
    .memWrData(memWrData));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(string n, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // one bus or fragment cycle, launched right after the edge
  task automatic drv(logic wv, logic rv, logic [7:0] a, logic [31:0] d, logic fv, logic fp);
    @(posedge clk);
    regWr <= wv;
    regRd <= rv;
    regAddr <= a;
    regWdata <= d;
    fragValid <= fv;
    fragPass <= fp;
    fragS <= s;
    fragT <= t;
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] x);
    drv(0, 1, a, rnd(), 0, 0);
    expQ.push_back('{3'b100, x, 0, 0});
  endtask
  // ==========================================================
  // watcher: each result takes the oldest note
  always @(posedge clk) begin
    if (!rst) begin
      rdQ <= regRd;
      if (rdQ || memWrValid || texReqValid) begin
        e = (expQ.size() > 0) ? expQ.pop_front() : '{3'b000, 0, 0, 0};
        check("kind", {29'h0, rdQ, memWrValid, texReqValid}, {29'h0, e.k});
        if (e.k[2]) check("regRdata", regRdata, e.a);
        if (e.k[1]) check("memWrAddr", {8'h0, memWrAddr}, e.a);
        if (e.k[1]) check("memWrData", memWrData, e.b);
        if (e.k[0]) check("texTexelAddr", {8'h0, texTexelAddr}, e.a);
        if (e.k[0]) check("texByteAddr", {6'h0, texByteAddr}, e.b);
        if (e.k[0]) check("texST", {10'h0, texT, texS}, e.c);
      end
    end
  end
  initial begin
    repeat (2000) @(posedge clk);
    mismatches++;
    finish_test();
  end
  // ==========================================================
  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd(TXA_ADDR_DL_PTR, 0);
    rd(TXA_ADDR_FETCH_CFG, TXA_CFG_RESET);
    p = rnd();
    drv(1, 0, TXA_ADDR_DL_PTR, {8'h0, p}, 0, 0);
    for (int i = 0; i < 3; i++) begin
      w = rnd();
      if (i == 0) w0 = w;
      drv(1, 0, TXA_ADDR_RAW_WORD, w, 0, 0);
      expQ.push_back('{3'b010, {8'h0, p + 24'(i)}, w, 0});
    end
    rd(TXA_ADDR_DL_PTR, {8'h0, p + 24'h3});
    rd(TXA_ADDR_STATUS, 3);
    rd(TXA_ADDR_RAW_WORD, 0);
    rd(8'h20, 0);
    b = rnd();
    drv(1, 0, TXA_ADDR_BASE, {8'h0, b}, 0, 0);
    for (int f = 0; f < 5; f++) begin
      // even: 512+128 via low and mid codes; odd: 1024 via high code
      cfg = {10'h0, 4'(f + 2), 4'(f + 1), 4'(f), f[0], f[0] ? 9'o600 : 9'o035};
      drv(1, 0, TXA_ADDR_FETCH_CFG, cfg, 0, 0);
      s = 11'(rnd());
      t = 11'(rnd());
      drv(0, 0, 8'h00, 0, 1, 1);
      ea = f[0] ? b + 24'(t) * 24'd1024 + 24'(s) : b - 24'(t) * 24'd640 + 24'(s);
      expQ.push_back('{3'b001, {8'h0, ea}, (f == 2) ? {6'h0, ea, 2'b0} :
        (f == 4) ? {9'h0, ea[23:1]} : f[0] ? {7'h0, ea, 1'b0} : {8'h0, ea}, {10'h0, t, s}});
      drv(0, 0, 8'h00, 0, 1, 0);
      check("wrapWidthLog", {28'h0, wrapWidthLog}, f + 1);
      check("wrapHeightLog", {28'h0, wrapHeightLog}, f + 2);
    end
    drv(0, 0, 8'h00, 0, 0, 0);
    repeat (4) @(posedge clk);
    check("memWords", mem.writes, 3);
    check("memFirst", mem.mem[int'(p)], w0);
    check("notesLeft", expQ.size(), 0);
    finish_test();
  end
endmodule
